//--- hdl/rsw_map.svh
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

// Oscillator rate in kHz.
`define RSW_CLK_KHZ 20000
// Reset hold time in ms, inside the 140 to 400 ms window.
`define RSW_HOLD_MS 200
// Watchdog period in ms.
`define RSW_WD_MS 1600
// Least stable time of the manual reset input in ns.
`define RSW_DEBOUNCE_NS 1000
// Supply dips shorter than this time in ns are ignored.
`define RSW_DIP_NS 2000
// The strobe is pulled high for the last 1/8 of each period.
`define RSW_PULL_HI_DIV 8
// Default reset output polarity, one for active low.
`define RSW_RESET_ACTIVE_LOW 1'b1
// Reset values of the filtered inputs.
`define RSW_SUPPLY_INIT 1'b0
`define RSW_MR_INIT 1'b1
`define RSW_STROBE_INIT 1'b0

`endif

//--- hdl/rsw_pkg.sv
package rsw_pkg;

  typedef enum logic [1:0] {
    rsw_st_assert,
    rsw_st_hold,
    rsw_st_run
  } rsw_rst_state_t;

endpackage : rsw_pkg

//--- hdl/rsw_filter.sv
`timescale 1ns/10ps

module rsw_filter #(
  parameter int unsigned COUNT = 1,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);

  logic sync1_ff;
  logic sync2_ff;
  logic out_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic differ;
  logic accept;

  // Two flops bring the pin into the clock domain; the level must then stay stable.
  assign differ = sync2_ff != out_ff;
  assign accept = differ && (cnt_ff == 16'(COUNT - 1));
  assign nxt_cnt = (differ && !accept) ? cnt_ff + 16'h0001 : 16'h0000;
  assign dout = out_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= INIT;
      sync2_ff <= INIT;
      out_ff <= INIT;
      cnt_ff <= 16'h0000;
    end else begin
      sync1_ff <= din;
      sync2_ff <= sync1_ff;
      cnt_ff <= nxt_cnt;
      if (accept) begin
        out_ff <= sync2_ff;
      end
    end
  end

endmodule : rsw_filter

//--- hdl/rsw_top.sv
// Operation
// - After the supply comes good, reset stays asserted for the hold time before release.
// - A supply that stays low for the 2 us dip time asserts reset and holds it while the supply stays low.
// - A low manual reset input asserts reset; the input idles high when unconnected.
// - The manual reset input is debounced so each press held for at least 1 us gives at least a full hold pulse.
// - The hold countdown after a manual reset starts only once the input is high again.
// - The fault output goes low when the strobe shows no edge within the watchdog period.
// - Any strobe edge before expiry restarts the watchdog count from zero.
// - The watchdog count stays idle while reset is asserted and runs once it is released.
// - A low supply drives the fault output low whatever the watchdog count is.
// - A floating strobe input disables the watchdog, so no fault is raised.
// - The strobe is weakly pulled low for 7/8 of each period and high for the last 1/8.
// - The pull pattern repeats every period, even while a driver holds the strobe, which re-enables checking.
// - Supply dips shorter than about 2 us are filtered out and do not cause reset.
// - The reset hold time lies between 140 ms and 400 ms, typically 200 ms.
`timescale 1ns/10ps
`include "rsw_map.svh"

module rsw_top #(
  parameter logic [21:0] HOLD_CYC = 22'(`RSW_HOLD_MS * `RSW_CLK_KHZ),
  parameter logic [24:0] WD_CYC = 25'(`RSW_WD_MS * `RSW_CLK_KHZ),
  parameter logic RESET_ACTIVE_LOW = `RSW_RESET_ACTIVE_LOW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic manual_reset_n,
  input wire logic watchdog_strobe_in,
  output logic watchdog_strobe_out,
  output logic watchdog_strobe_oe,
  output logic cpu_reset,
  output logic watchdog_fault_n
);

  // Least times round up to whole cycles.
  localparam int unsigned DEB_CYC = (`RSW_DEBOUNCE_NS * `RSW_CLK_KHZ + 999999) / 1000000;
  localparam int unsigned DIP_CYC = (`RSW_DIP_NS * `RSW_CLK_KHZ + 999999) / 1000000;
  localparam logic [24:0] PH_HI = WD_CYC - (WD_CYC / 25'(`RSW_PULL_HI_DIV));

  logic supply_q;
  logic mr_q;
  logic strobe_q;
  logic supply_bad;
  logic cause;
  rsw_pkg::rsw_rst_state_t state_ff;
  rsw_pkg::rsw_rst_state_t nxt_state;
  logic [21:0] hold_cnt_ff;
  logic [21:0] nxt_hold_cnt;
  logic reset_active;
  logic nxt_reset_active;
  logic cpu_reset_ff;
  logic strobe_prev_ff;
  logic toggle;
  logic [24:0] wd_cnt_ff;
  logic [24:0] nxt_wd_cnt;
  logic fault_n_ff;
  logic [24:0] phase_ff;
  logic [24:0] nxt_phase;
  logic pull_out_ff;
  logic pull_oe_ff;
  logic follow_lo_ff;
  logic open_ff;
  logic low_end;
  logic period_end;

  rsw_filter #(.COUNT(DIP_CYC), .INIT(`RSW_SUPPLY_INIT)) u_supply (
    .clk(clk),
    .rst_n(rst_n),
    .din(supply_ok),
    .dout(supply_q)
  );

  rsw_filter #(.COUNT(DEB_CYC), .INIT(`RSW_MR_INIT)) u_mr (
    .clk(clk),
    .rst_n(rst_n),
    .din(manual_reset_n),
    .dout(mr_q)
  );

  rsw_filter #(.COUNT(1), .INIT(`RSW_STROBE_INIT)) u_strobe (
    .clk(clk),
    .rst_n(rst_n),
    .din(watchdog_strobe_in),
    .dout(strobe_q)
  );

  assign supply_bad = !supply_q;
  assign cause = supply_bad || !mr_q;
  assign reset_active = state_ff != rsw_pkg::rsw_st_run;
  assign nxt_reset_active = nxt_state != rsw_pkg::rsw_st_run;

  // Any cause sends the machine back to assert; hold counts only with no cause present.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rsw_pkg::rsw_st_assert: begin
        if (!cause) begin
          nxt_state = rsw_pkg::rsw_st_hold;
        end
      end
      rsw_pkg::rsw_st_hold: begin
        if (cause) begin
          nxt_state = rsw_pkg::rsw_st_assert;
        end else if (hold_cnt_ff == HOLD_CYC - 22'h00_0001) begin
          nxt_state = rsw_pkg::rsw_st_run;
        end
      end
      rsw_pkg::rsw_st_run: begin
        if (cause) begin
          nxt_state = rsw_pkg::rsw_st_assert;
        end
      end
      default: begin
        nxt_state = rsw_pkg::rsw_st_assert;
      end
    endcase
  end

  assign nxt_hold_cnt = (state_ff == rsw_pkg::rsw_st_hold && !cause) ?
                        hold_cnt_ff + 22'h00_0001 : 22'h00_0000;

  // Watchdog: cleared by reset, by the open state and by every strobe edge.
  assign toggle = strobe_q != strobe_prev_ff;
  assign nxt_wd_cnt = (reset_active || open_ff || toggle) ? 25'h000_0000 :
                      (wd_cnt_ff == WD_CYC - 25'h000_0001) ? wd_cnt_ff :
                      wd_cnt_ff + 25'h000_0001;

  // Free-running period drives the weak pull pattern used for open detection.
  assign period_end = phase_ff == WD_CYC - 25'h000_0001;
  assign low_end = phase_ff == PH_HI - 25'h000_0001;
  assign nxt_phase = period_end ? 25'h000_0000 : phase_ff + 25'h000_0001;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= rsw_pkg::rsw_st_assert;
      hold_cnt_ff <= 22'h00_0000;
      cpu_reset_ff <= 1'b1 ^ RESET_ACTIVE_LOW;
      strobe_prev_ff <= `RSW_STROBE_INIT;
      wd_cnt_ff <= 25'h000_0000;
      fault_n_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
      cpu_reset_ff <= nxt_reset_active ^ RESET_ACTIVE_LOW;
      strobe_prev_ff <= strobe_q;
      wd_cnt_ff <= nxt_wd_cnt;
      fault_n_ff <= !(supply_bad || nxt_wd_cnt == WD_CYC - 25'h000_0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_ff <= 25'h000_0000;
      pull_out_ff <= 1'b0;
      pull_oe_ff <= 1'b0;
      follow_lo_ff <= 1'b0;
      open_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      pull_out_ff <= nxt_phase >= PH_HI;
      pull_oe_ff <= 1'b1;
      if (low_end) begin
        follow_lo_ff <= !strobe_q;
      end
      if (period_end) begin
        open_ff <= follow_lo_ff && strobe_q;
      end
    end
  end

  assign cpu_reset = cpu_reset_ff;
  assign watchdog_fault_n = fault_n_ff;
  assign watchdog_strobe_out = pull_out_ff;
  assign watchdog_strobe_oe = pull_oe_ff;

  logic [22:0] quiet_ff;
  logic out_active;
  assign out_active = cpu_reset_ff ^ RESET_ACTIVE_LOW;

  always_ff @(posedge clk) begin
    if (!rst_n || cause) begin
      quiet_ff <= 23'h00_0000;
    end else if (quiet_ff != 23'h7F_FFFF) begin
      quiet_ff <= quiet_ff + 23'h00_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_period_end_driven_low;
    period_end && !strobe_q;
  endsequence

  AST_HOLD_EXACT: assert property ($fell(out_active) |->
    quiet_ff == {1'b0, HOLD_CYC} + 23'h00_0001)
    else $error("Reset released without the full hold time.");
  AST_SUPPLY_RESET: assert property (supply_bad |=> out_active)
    else $error("Low supply did not assert reset.");
  AST_MR_RESET: assert property (!mr_q |=> out_active [*2])
    else $error("Manual reset low did not hold reset.");
  AST_WD_FAULT: assert property (!watchdog_fault_n |->
    $past(supply_bad) || wd_cnt_ff == WD_CYC - 25'h000_0001)
    else $error("Fault low with no cause.");
  AST_WD_RESTART: assert property (toggle |=>
    wd_cnt_ff == 25'h000_0000 ##1 wd_cnt_ff <= 25'h000_0001)
    else $error("Strobe edge did not restart the watchdog.");
  AST_WD_IDLE: assert property (reset_active |=> wd_cnt_ff == 25'h000_0000)
    else $error("Watchdog counted during reset.");
  AST_SUPPLY_FAULT: assert property (supply_bad |=> !watchdog_fault_n)
    else $error("Low supply did not drive fault low.");
  AST_OPEN_NOFAULT: assert property (open_ff && !supply_bad |=> watchdog_fault_n)
    else $error("Fault raised while strobe is open.");
  AST_PULL_LOW: assert property (period_end |=> !watchdog_strobe_out [*8])
    else $error("Pull not low at the start of the period.");
  AST_PULL_HIGH: assert property (low_end |=> watchdog_strobe_out [*8])
    else $error("Pull not high in the last part of the period.");
  AST_DRIVEN_EXITS_OPEN: assert property (s_period_end_driven_low |=> !open_ff)
    else $error("Driven strobe left the watchdog disabled.");

endmodule : rsw_top

//--- verif/rsw_cpu_model.sv
`timescale 1ns/10ps

module rsw_cpu_model (
  input wire logic clk,
  input wire logic float_pin,
  input wire logic drive_val,
  input wire logic strobe_out,
  input wire logic strobe_oe,
  output logic strobe_pin
);
  logic last_ff;

  always_ff @(posedge clk) begin
    last_ff <= strobe_pin;
  end

  // The processor holds the strobe low and pulses it high to service.
  // An open pin follows the weak pull, or wanders when nothing pulls it.
  assign strobe_pin = !float_pin ? drive_val : (strobe_oe ? strobe_out : !last_ff);
endmodule : rsw_cpu_model

//--- verif/tb.sv
`timescale 1ns/10ps

module tb;
  localparam int HOLD = 50;
  localparam int WD = 400;
  logic clk, rst_n, supply_ok, manual_reset_n, drv, flt, tog, pin_q;
  logic strobe_pin, strobe_out, strobe_oe, cpu_reset, fault_n;
  logic cpu_reset_hi, fault_n_hi, strobe_out_hi, strobe_oe_hi;
  logic last_rst = 1'b0;
  logic last_flt = 1'b0;
  int fails, cmp_count, since_cause, since_edge, hi_cnt, h0, ph;
  logic rst_q[$];
  logic flt_q[$];

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  rsw_top #(.HOLD_CYC(22'(HOLD)), .WD_CYC(25'(WD)), .RESET_ACTIVE_LOW(1'b1)) u_rsw_top (
    .clk(clk),
    .rst_n(rst_n),
    .supply_ok(supply_ok),
    .manual_reset_n(manual_reset_n),
    .watchdog_strobe_in(strobe_pin),
    .watchdog_strobe_out(strobe_out),
    .watchdog_strobe_oe(strobe_oe),
    .cpu_reset(cpu_reset),
    .watchdog_fault_n(fault_n)
  );

  // Active-high variant on the same inputs; it must mirror the default one.
  rsw_top #(.HOLD_CYC(22'(HOLD)), .WD_CYC(25'(WD)), .RESET_ACTIVE_LOW(1'b0)) u_rsw_top_hi (
    .clk(clk),
    .rst_n(rst_n),
    .supply_ok(supply_ok),
    .manual_reset_n(manual_reset_n),
    .watchdog_strobe_in(strobe_pin),
    .watchdog_strobe_out(strobe_out_hi),
    .watchdog_strobe_oe(strobe_oe_hi),
    .cpu_reset(cpu_reset_hi),
    .watchdog_fault_n(fault_n_hi)
  );

  rsw_cpu_model u_rsw_cpu_model (
    .clk(clk),
    .float_pin(flt),
    .drive_val(drv),
    .strobe_out(strobe_out),
    .strobe_oe(strobe_oe),
    .strobe_pin(strobe_pin)
  );

  task compare_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : compare_bit

  task tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  // Stops the strobe, expects a fault, then resumes and expects it to clear.
  task starve;
    flt_q.push_back(1'b0);
    flt_q.push_back(1'b1);
    tog <= 1'b0;
    cycles(800);
    tog <= 1'b1;
    cycles(600);
  endtask : starve

  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      since_cause <= (!supply_ok || !manual_reset_n) ? 0 : since_cause + 1;
      since_edge <= (strobe_pin !== pin_q) ? 0 : since_edge + 1;
      pin_q <= strobe_pin;
      hi_cnt <= hi_cnt + int'(strobe_out);
      ph <= (ph == WD - 1) ? 0 : ph + 1;
      compare_bit({cpu_reset_hi, fault_n_hi, strobe_out_hi, strobe_oe_hi} ==
                  {!cpu_reset, fault_n, strobe_out, strobe_oe}, 1'b1);
      if (cpu_reset !== last_rst) begin
        compare_bit(cpu_reset, rst_q.size() > 0 ? rst_q.pop_front() : last_rst);
        if (cpu_reset === 1'b1) begin
          compare_bit(since_cause >= HOLD && since_cause < HOLD + 80, 1'b1);
        end
      end
      if (fault_n !== last_flt) begin
        compare_bit(fault_n, flt_q.size() > 0 ? flt_q.pop_front() : last_flt);
        if (fault_n === 1'b0 && supply_ok) begin
          compare_bit(since_edge >= WD && since_edge < WD + 8, 1'b1);
        end
      end
      last_rst <= cpu_reset;
      last_flt <= fault_n;
    end
  end

  // Random service pulses, always well inside the watchdog period.
  always begin
    @(posedge clk);
    if (tog) begin
      cycles(100 + int'($urandom % 200));
      // Keep each pulse clear of the period end, where a high strobe looks open.
      for (int i = 0; i < 40 && ph > WD - 32; i++) begin
        @(posedge clk);
      end
      if (ph > WD - 32) begin
        fails++;
        tally_and_finish();
      end
      drv <= 1'b1;
      cycles(10);
      drv <= 1'b0;
    end
  end

  initial begin
    cycles(20000);
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(61609));
    rst_n = 1'b0;
    supply_ok = 1'b0;
    manual_reset_n = 1'b1;
    drv = 1'b0;
    flt = 1'b0;
    tog = 1'b0;
    pin_q = 1'b0;
    hi_cnt = 0;
    cycles(3);
    rst_n <= 1'b1;
    rst_q.push_back(1'b1);
    flt_q.push_back(1'b1);
    supply_ok <= 1'b1;
    tog <= 1'b1;
    cycles(300);
    supply_ok <= 1'b0;
    cycles(20);
    supply_ok <= 1'b1;
    cycles(200);
    manual_reset_n <= 1'b0;
    cycles(10);
    manual_reset_n <= 1'b1;
    cycles(100);
    rst_q.push_back(1'b0);
    rst_q.push_back(1'b1);
    manual_reset_n <= 1'b0;
    cycles(100);
    manual_reset_n <= 1'b1;
    cycles(300);
    starve();
    tog <= 1'b0;
    cycles(320);
    drv <= 1'b1;
    cycles(10);
    drv <= 1'b0;
    flt <= 1'b1;
    cycles(2 * WD);
    h0 = hi_cnt;
    cycles(8 * WD);
    compare_bit(hi_cnt - h0 == WD, 1'b1);
    compare_bit(strobe_oe, 1'b1);
    flt <= 1'b0;
    tog <= 1'b1;
    cycles(500);
    starve();
    rst_q.push_back(1'b0);
    flt_q.push_back(1'b0);
    supply_ok <= 1'b0;
    cycles(300);
    rst_q.push_back(1'b1);
    flt_q.push_back(1'b1);
    supply_ok <= 1'b1;
    cycles(400);
    compare_bit(rst_q.size() == 0 && flt_q.size() == 0, 1'b1);
    tally_and_finish();
  end
endmodule : tb
